//--- hpio_bank.sv
// Hub pin control bank: AXI4-Lite register slave driving sense, indicator and port power pins.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module hpio_bank (
  // Clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           rst,
  // AXI4-Lite write address and data
  input  wire logic [hpio_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [hpio_pkg::DATA_W-1:0]    s_axi_wdata,
  input  wire logic [hpio_pkg::DATA_W/8-1:0]  s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  // AXI4-Lite read
  input  wire logic [hpio_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [hpio_pkg::DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  // Bus-voltage sense (bit 0) and over-current sense pins (bits 1 to 4)
  input  wire logic [hpio_pkg::SENSE_N-1:0]   sense_pin_in,
  output logic [hpio_pkg::SENSE_N-1:0]        sense_pin_out,
  output logic [hpio_pkg::SENSE_N-1:0]        sense_pin_oe,
  output logic [hpio_pkg::SENSE_N-1:0]        sense_pin_pullup,
  // Indicator pin
  input  wire logic                           indicator_pin_in,
  output logic                                indicator_pin_out,
  output logic                                indicator_pin_oe,
  output logic                                indicator_pin_pullup,
  input  wire logic                           indicator_led_level,
  // Port power pins 7 to 1
  input  wire logic [hpio_pkg::PP_HI:hpio_pkg::PP_LO] port_power_pin_in,
  output logic [hpio_pkg::PP_HI:hpio_pkg::PP_LO]      port_power_pin_out,
  output logic [hpio_pkg::PP_HI:hpio_pkg::PP_LO]      port_power_pin_oe,
  output logic [hpio_pkg::PP_HI:hpio_pkg::PP_LO]      port_power_pin_pulldown
);
  import hpio_pkg::*;

  function automatic hpio_sel_t reg_decode(input logic [ADDR_W-1:0] addr);
    logic [13:0] idx;
    idx = addr[ADDR_W-1:2];
    case (idx)
      IDX_SENSE_DIR: reg_decode = SEL_SENSE_DIR;
      IDX_IND_DIR:   reg_decode = SEL_IND_DIR;
      IDX_SENSE_OUT: reg_decode = SEL_SENSE_OUT;
      IDX_IND_OUT:   reg_decode = SEL_IND_OUT;
      IDX_SENSE_IN:  reg_decode = SEL_SENSE_IN;
      IDX_IND_IN:    reg_decode = SEL_IND_IN;
      IDX_SENSE_PU:  reg_decode = SEL_SENSE_PU;
      IDX_IND_PU:    reg_decode = SEL_IND_PU;
      IDX_IND_MODE:  reg_decode = SEL_IND_MODE;
      IDX_PP_PD:     reg_decode = SEL_PP_PD;
      IDX_PP_DIR:    reg_decode = SEL_PP_DIR;
      IDX_PP_OUT:    reg_decode = SEL_PP_OUT;
      IDX_PP_IN:     reg_decode = SEL_PP_IN;
      default:       reg_decode = SEL_NONE;
    endcase
  endfunction

  logic [REG_W-1:0]    sense_dir_reg;
  logic [REG_W-1:0]    ind_dir_reg;
  logic [REG_W-1:0]    sense_out_reg;
  logic [REG_W-1:0]    ind_out_reg;
  logic [REG_W-1:0]    sense_pu_reg;
  logic [REG_W-1:0]    ind_pu_reg;
  logic [REG_W-1:0]    ind_mode_reg;
  logic [REG_W-1:0]    pp_pd_reg;
  logic [REG_W-1:0]    pp_dir_reg;
  logic [REG_W-1:0]    pp_out_reg;
  logic                ind_drive_reg;
  logic [SENSE_N-1:0]  sense_meta_reg;
  logic [SENSE_N-1:0]  sense_sync_reg;
  logic                ind_meta_reg;
  logic                ind_sync_reg;
  logic [PP_HI:PP_LO]  pp_meta_reg;
  logic [PP_HI:PP_LO]  pp_sync_reg;
  logic                aw_held_reg;
  logic [ADDR_W-1:0]   awaddr_reg;
  logic                w_held_reg;
  logic [REG_W-1:0]    wdata_reg;
  logic                wlane_reg;
  logic                bvalid_reg;
  logic [1:0]          bresp_reg;
  logic                rvalid_reg;
  logic [DATA_W-1:0]   rdata_reg;
  logic [1:0]          rresp_reg;
  logic                do_write;
  hpio_sel_t           wr_sel;
  hpio_sel_t           rd_sel;
  logic                wr_en;
  logic [REG_W-1:0]    rd_next;

  // Address and data are taken in either order; the write lands once both are held.
  assign s_axi_awready = ~aw_held_reg;
  assign s_axi_wready  = ~w_held_reg;
  assign do_write      = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wr_sel        = reg_decode(awaddr_reg);
  assign wr_en         = do_write & wlane_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign rd_sel        = reg_decode(s_axi_araddr);
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= '0;
      w_held_reg  <= 1'b0;
      wdata_reg   <= REG_RST;
      wlane_reg   <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata[REG_W-1:0];
        wlane_reg  <= s_axi_wstrb[LANE0_BIT];
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Whole bytes are stored, so reserved bits of writable registers keep what was written.
  // reserved bits stored
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sense_dir_reg <= REG_RST;
      ind_dir_reg   <= REG_RST;
      sense_out_reg <= REG_RST;
      ind_out_reg   <= REG_RST;
      sense_pu_reg  <= REG_RST;
      ind_pu_reg    <= REG_RST;
      ind_mode_reg  <= REG_RST;
      pp_pd_reg     <= REG_RST;
      pp_dir_reg    <= REG_RST;
      pp_out_reg    <= REG_RST;
    end else if (wr_en) begin
      case (wr_sel)
        SEL_SENSE_DIR: sense_dir_reg <= wdata_reg;
        SEL_IND_DIR:   ind_dir_reg   <= wdata_reg;
        SEL_SENSE_OUT: sense_out_reg <= wdata_reg;
        SEL_IND_OUT:   ind_out_reg   <= wdata_reg;
        SEL_SENSE_PU:  sense_pu_reg  <= wdata_reg;
        SEL_IND_PU:    ind_pu_reg    <= wdata_reg;
        SEL_IND_MODE:  ind_mode_reg  <= wdata_reg;
        SEL_PP_PD:     pp_pd_reg     <= wdata_reg;
        SEL_PP_DIR:    pp_dir_reg    <= wdata_reg;
        SEL_PP_OUT:    pp_out_reg    <= wdata_reg;
        default:       ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sense_meta_reg <= SENSE_RST;
      sense_sync_reg <= SENSE_RST;
      ind_meta_reg   <= BIT_RST;
      ind_sync_reg   <= BIT_RST;
      pp_meta_reg    <= PP_RST;
      pp_sync_reg    <= PP_RST;
    end else begin
      sense_meta_reg <= sense_pin_in;
      sense_sync_reg <= sense_meta_reg;
      ind_meta_reg   <= indicator_pin_in;
      ind_sync_reg   <= ind_meta_reg;
      pp_meta_reg    <= port_power_pin_in;
      pp_sync_reg    <= pp_meta_reg;
    end
  end

  always_comb begin
    rd_next = REG_RST;
    case (rd_sel)
      SEL_SENSE_DIR: rd_next = sense_dir_reg;
      SEL_IND_DIR:   rd_next = ind_dir_reg;
      SEL_SENSE_OUT: rd_next = sense_out_reg;
      SEL_IND_OUT:   rd_next = ind_out_reg;
      SEL_SENSE_IN:  rd_next[SENSE_N-1:0] = sense_sync_reg;
      SEL_IND_IN:    rd_next[IND_BIT] = ind_sync_reg;
      SEL_SENSE_PU:  rd_next = sense_pu_reg;
      SEL_IND_PU:    rd_next = ind_pu_reg;
      SEL_IND_MODE:  rd_next = ind_mode_reg;
      SEL_PP_PD:     rd_next = pp_pd_reg;
      SEL_PP_DIR:    rd_next = pp_dir_reg;
      SEL_PP_OUT:    rd_next = pp_out_reg;
      SEL_PP_IN:     rd_next[PP_HI:PP_LO] = pp_sync_reg;
      default:       rd_next = REG_RST;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= {{(DATA_W-REG_W){1'b0}}, rd_next};
      rresp_reg  <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // The indicator level is registered so that the pin never follows a glitch of the blink logic.
  // data bit only in programmable mode
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ind_drive_reg <= BIT_RST;
    end else if (ind_mode_reg[MODE_BIT]) begin
      ind_drive_reg <= indicator_led_level;
    end else begin
      ind_drive_reg <= ind_out_reg[IND_BIT];
    end
  end

  assign sense_pin_oe      = sense_dir_reg[SENSE_N-1:0];
  assign sense_pin_out     = sense_out_reg[SENSE_N-1:0];
  assign sense_pin_pullup  = sense_pu_reg[SENSE_N-1:0];
  assign indicator_pin_oe  = ind_dir_reg[IND_BIT];
  assign indicator_pin_out = ind_drive_reg;
  assign indicator_pin_pullup = ind_pu_reg[IND_BIT];
  assign port_power_pin_pulldown = pp_pd_reg[PP_HI:PP_LO];
  assign port_power_pin_oe  = pp_dir_reg[PP_HI:PP_LO];
  assign port_power_pin_out = pp_out_reg[PP_HI:PP_LO];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_sense_dir_write: assert property (
    (wr_en && wr_sel == SEL_SENSE_DIR) |=> (sense_pin_oe == $past(wdata_reg[SENSE_N-1:0])))
    else $error("Sense direction write did not reach the output enables.");

  chk_ind_dir_write: assert property (
    (wr_en && wr_sel == SEL_IND_DIR) |=> (indicator_pin_oe == $past(wdata_reg[IND_BIT])))
    else $error("Indicator direction write did not reach the output enable.");

  chk_sense_out_write: assert property (
    (wr_en && wr_sel == SEL_SENSE_OUT) |=> (sense_pin_out == $past(wdata_reg[SENSE_N-1:0])))
    else $error("Sense output write did not reach the pins.");

  chk_ind_mode_mux: assert property (
    ##1 (indicator_pin_out == ($past(ind_mode_reg[MODE_BIT]) ? $past(indicator_led_level)
                                                             : $past(ind_out_reg[IND_BIT]))))
    else $error("Indicator pin took the wrong source for its mode.");

  chk_sense_in_read: assert property (
    (s_axi_arvalid && s_axi_arready && rd_sel == SEL_SENSE_IN)
      |=> (s_axi_rvalid && s_axi_rdata == {{(DATA_W-SENSE_N){1'b0}}, $past(sense_sync_reg)}))
    else $error("Sense input read returned wrong data.");

  chk_pp_in_read: assert property (
    (s_axi_arvalid && s_axi_arready && rd_sel == SEL_PP_IN)
      |=> (s_axi_rdata[PP_LO-1] == 1'b0 && s_axi_rdata[PP_HI:PP_LO] == $past(pp_sync_reg)))
    else $error("Port power input read returned wrong data.");

  chk_pp_dir_write: assert property (
    (wr_en && wr_sel == SEL_PP_DIR) |=> (port_power_pin_oe == $past(wdata_reg[PP_HI:PP_LO])))
    else $error("Port power direction write did not reach the enables.");

  chk_pp_pd_write: assert property (
    (wr_en && wr_sel == SEL_PP_PD) |=> (port_power_pin_pulldown == $past(wdata_reg[PP_HI:PP_LO])))
    else $error("Port power pull-down write did not reach the pads.");

  chk_sync_two_stage: assert property (
    (!$past(rst) && !$past(rst, 2))
      |-> ((sense_sync_reg == $past(sense_pin_in, 2)) && (pp_sync_reg == $past(port_power_pin_in, 2))))
    else $error("Input synchronizer delay is not two cycles.");

  chk_write_answer: assert property (
    do_write |=> (s_axi_bvalid && (s_axi_bresp == RESP_SLVERR) == ($past(wr_sel) == SEL_NONE)))
    else $error("Write response missing or wrong.");

  chk_sense_pu_write: assert property (
    (wr_en && wr_sel == SEL_SENSE_PU) |=> (sense_pin_pullup == $past(wdata_reg[SENSE_N-1:0])))
    else $error("Sense pull-up write did not reach the pins.");

  chk_ind_pu_write: assert property (
    (wr_en && wr_sel == SEL_IND_PU) |=> (indicator_pin_pullup == $past(wdata_reg[IND_BIT])))
    else $error("Indicator pull-up write did not reach the pin.");

  chk_pp_out_write: assert property (
    (wr_en && wr_sel == SEL_PP_OUT) |=> (port_power_pin_out == $past(wdata_reg[PP_HI:PP_LO])))
    else $error("Port power output write did not reach the pins.");

  chk_ind_out_prog: assert property (
    (wr_en && wr_sel == SEL_IND_OUT && !ind_mode_reg[MODE_BIT])
      |=> ##1 (indicator_pin_out == $past(wdata_reg[IND_BIT], 2)))
    else $error("Indicator output write did not reach the pin in programmable mode.");

  chk_ind_in_read: assert property (
    (s_axi_arvalid && s_axi_arready && rd_sel == SEL_IND_IN)
      |=> (s_axi_rvalid && s_axi_rdata == {{(DATA_W-1){1'b0}}, $past(ind_sync_reg)}))
    else $error("Indicator input read returned wrong data.");

  chk_in_write_ignored: assert property (
    (wr_en && (wr_sel == SEL_SENSE_IN || wr_sel == SEL_IND_IN || wr_sel == SEL_PP_IN))
      |=> ($stable({sense_dir_reg, ind_dir_reg, sense_out_reg, ind_out_reg, sense_pu_reg, ind_pu_reg}) &&
           $stable({ind_mode_reg, pp_pd_reg, pp_dir_reg, pp_out_reg})))
    else $error("Write to an input register changed stored state.");

  chk_data_keeps_enable: assert property (
    (wr_en && wr_sel != SEL_SENSE_DIR && wr_sel != SEL_IND_DIR && wr_sel != SEL_PP_DIR)
      |=> ($stable(sense_pin_oe) && $stable(indicator_pin_oe) && $stable(port_power_pin_oe)))
    else $error("Pin drivers changed without a direction write.");

  chk_rsvd_read_zero: assert property (
    s_axi_rvalid |-> (s_axi_rdata[DATA_W-1:REG_W] == '0))
    else $error("Read data above the register byte is not zero.");

  chk_unmapped_read: assert property (
    (s_axi_arvalid && s_axi_arready && rd_sel == SEL_NONE)
      |=> (s_axi_rvalid && s_axi_rdata == '0 && s_axi_rresp == RESP_SLVERR))
    else $error("Unmapped read did not return zero with an error response.");

  chk_ind_sync_two: assert property (
    (!$past(rst) && !$past(rst, 2)) |-> (ind_sync_reg == $past(indicator_pin_in, 2)))
    else $error("Indicator synchronizer delay is not two cycles.");

endmodule
`default_nettype wire

//--- hpio_pkg.sv
// Package with register map, reset values and bus constants of the hub pin control bank.
`default_nettype none
package hpio_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;

  // Register indices as numbered in the map; the byte address is four times the index.
  localparam logic [13:0] IDX_SENSE_DIR  = 14'h0831;
  localparam logic [13:0] IDX_IND_DIR    = 14'h0833;
  localparam logic [13:0] IDX_SENSE_OUT  = 14'h0835;
  localparam logic [13:0] IDX_IND_OUT    = 14'h0837;
  localparam logic [13:0] IDX_SENSE_IN   = 14'h0839;
  localparam logic [13:0] IDX_IND_IN     = 14'h083b;
  localparam logic [13:0] IDX_SENSE_PU   = 14'h083d;
  localparam logic [13:0] IDX_IND_PU     = 14'h083f;
  localparam logic [13:0] IDX_IND_MODE   = 14'h0840;
  localparam logic [13:0] IDX_PP_PD      = 14'h092e;
  localparam logic [13:0] IDX_PP_DIR     = 14'h0932;
  localparam logic [13:0] IDX_PP_OUT     = 14'h0936;
  localparam logic [13:0] IDX_PP_IN      = 14'h093a;

  // Pin counts and field positions.
  localparam int unsigned SENSE_N   = 5;
  localparam int unsigned PP_LO     = 1;
  localparam int unsigned PP_HI     = 7;
  localparam int unsigned IND_BIT   = 0;
  localparam int unsigned MODE_BIT  = 0;
  localparam int unsigned LANE0_BIT = 0;

  // Reset values; every pin starts as an input with pulls off, indicator in programmable mode.
  localparam logic [7:0] REG_RST    = 8'h00;
  localparam logic [4:0] SENSE_RST  = 5'h00;
  localparam logic [7:1] PP_RST     = 7'h00;
  localparam logic       BIT_RST    = 1'b0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    SEL_NONE      = 4'h0,
    SEL_SENSE_DIR = 4'h1,
    SEL_IND_DIR   = 4'h2,
    SEL_SENSE_OUT = 4'h3,
    SEL_IND_OUT   = 4'h4,
    SEL_SENSE_IN  = 4'h5,
    SEL_IND_IN    = 4'h6,
    SEL_SENSE_PU  = 4'h7,
    SEL_IND_PU    = 4'h8,
    SEL_IND_MODE  = 4'h9,
    SEL_PP_PD     = 4'ha,
    SEL_PP_DIR    = 4'hb,
    SEL_PP_OUT    = 4'hc,
    SEL_PP_IN     = 4'hd
  } hpio_sel_t;

endpackage
`default_nettype wire

//--- hpio_pins_model.sv
// Pin world model: external sense circuits, power switches and pulls around the pin bank.
`timescale 1ns/10ps
`default_nettype none
module hpio_pins_model (
  // Clock
  input  wire logic       sys_clk,
  // Bank pin controls
  input  wire logic [4:0] s_out,
  input  wire logic [4:0] s_oe,
  input  wire logic [4:0] s_pu,
  input  wire logic       i_out,
  input  wire logic       i_oe,
  input  wire logic       i_pu,
  input  wire logic [7:1] p_out,
  input  wire logic [7:1] p_oe,
  input  wire logic [7:1] p_pd,
  // External drivers
  input  wire logic       ext_en,
  input  wire logic [4:0] ext_s,
  input  wire logic       ext_i,
  input  wire logic [7:1] ext_p,
  // Resolved pin levels
  output logic [4:0]      s_lvl,
  output logic            i_lvl,
  output logic [7:1]      p_lvl
);
  logic tgl_reg;
  // An undriven pin without a pull wanders, so it flips every cycle instead of settling.
  always_ff @(posedge sys_clk) begin
    tgl_reg <= (tgl_reg === 1'b1) ? 1'b0 : 1'b1;
  end
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      s_lvl[k] = s_oe[k] ? s_out[k] : ext_en ? ext_s[k] : s_pu[k] ? 1'b1 : tgl_reg;
    end
    i_lvl = i_oe ? i_out : ext_en ? ext_i : i_pu ? 1'b1 : tgl_reg;
    for (int k = 1; k < 8; k++) begin
      p_lvl[k] = p_oe[k] ? p_out[k] : ext_en ? ext_p[k] : p_pd[k] ? 1'b0 : tgl_reg;
    end
  end
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for the hub pin control bank.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import hpio_pkg::*;
  logic        sys_clk, rst, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr;
  logic [15:0] awa, ara;
  logic [31:0] wd, rdat, d;
  logic [3:0]  ws;
  logic [1:0]  bresp, rresp, r;
  logic [4:0]  s_in, s_out, s_oe, s_pu, ext_s;
  logic        i_in, i_out, i_oe, i_pu, led, ext_en, ext_i;
  logic [7:1]  p_in, p_out, p_oe, p_pd, ext_p;
  logic [7:0]  sh [10];
  logic [15:0] at [13];
  int          num_errors, tests_run;
  always #2 sys_clk = ~sys_clk;
  hpio_bank hpio_bank_i (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .sense_pin_in(s_in), .sense_pin_out(s_out), .sense_pin_oe(s_oe), .sense_pin_pullup(s_pu),
    .indicator_pin_in(i_in), .indicator_pin_out(i_out), .indicator_pin_oe(i_oe), .indicator_pin_pullup(i_pu),
    .indicator_led_level(led), .port_power_pin_in(p_in), .port_power_pin_out(p_out),
    .port_power_pin_oe(p_oe), .port_power_pin_pulldown(p_pd));
  hpio_pins_model hpio_pins_model_i (.sys_clk(sys_clk), .s_out(s_out), .s_oe(s_oe), .s_pu(s_pu),
    .i_out(i_out), .i_oe(i_oe), .i_pu(i_pu), .p_out(p_out), .p_oe(p_oe), .p_pd(p_pd), .ext_en(ext_en),
    .ext_s(ext_s), .ext_i(ext_i), .ext_p(ext_p), .s_lvl(s_in), .i_lvl(i_in), .p_lvl(p_in));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic axw(input logic [15:0] a, input logic [7:0] v, input logic [3:0] st);
    int n;
    n = 0;
    @(posedge sys_clk);
    awa <= a; awv <= 1'b1; wd <= {24'h0, v}; ws <= st; wv <= 1'b1; br <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 200);
    if (n >= 200) num_errors++;
    r = bresp;
    br <= 1'b0;
  endtask
  task automatic axr(input logic [15:0] a);
    int n;
    n = 0;
    @(posedge sys_clk);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (arv && arr) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 200);
    if (n >= 200) num_errors++;
    d = rdat;
    r = rresp;
    rr <= 1'b0;
  endtask
  task automatic wreg(input int i, input logic [7:0] v);
    sh[i] = v;
    axw(at[i], v, 4'h1);
    check("write response", 32'(r), 32'(RESP_OKAY));
  endtask
  function automatic logic [7:0] exp_s();
    return {3'h0, (sh[0][4:0] & sh[2][4:0]) | (~sh[0][4:0] & ext_s)};
  endfunction
  function automatic logic [7:0] exp_p();
    return {(sh[7][7:1] & sh[8][7:1]) | (~sh[7][7:1] & ext_p), 1'b0};
  endfunction
  task automatic chk_pins;
    check("sense oe", 32'(s_oe), 32'(sh[0][4:0]));
    check("sense out", 32'(s_out), 32'(sh[2][4:0]));
    check("sense pullup", 32'(s_pu), 32'(sh[4][4:0]));
    check("indicator oe", 32'(i_oe), 32'(sh[1][0]));
    check("indicator out", 32'(i_out), 32'(sh[3][0]));
    check("indicator pullup", 32'(i_pu), 32'(sh[5][0]));
    check("power pulldown", 32'(p_pd), 32'(sh[6][7:1]));
    check("power oe", 32'(p_oe), 32'(sh[7][7:1]));
    check("power out", 32'(p_out), 32'(sh[8][7:1]));
  endtask
  initial begin
    sys_clk = 1'b0; rst = 1'b1; awv = 1'b0; wv = 1'b0; br = 1'b0; arv = 1'b0; rr = 1'b0;
    awa = 16'h0000; ara = 16'h0000; wd = 32'h0; ws = 4'h0; led = 1'b0;
    ext_en = 1'b1; ext_s = 5'h00; ext_i = 1'b0; ext_p = 7'h00;
    num_errors = 0; tests_run = 0;
    at = '{{IDX_SENSE_DIR, 2'h0}, {IDX_IND_DIR, 2'h0}, {IDX_SENSE_OUT, 2'h0}, {IDX_IND_OUT, 2'h0},
      {IDX_SENSE_PU, 2'h0}, {IDX_IND_PU, 2'h0}, {IDX_PP_PD, 2'h0}, {IDX_PP_DIR, 2'h0}, {IDX_PP_OUT, 2'h0},
      {IDX_IND_MODE, 2'h0}, {IDX_SENSE_IN, 2'h0}, {IDX_IND_IN, 2'h0}, {IDX_PP_IN, 2'h0}};
    for (int i = 0; i < 10; i++) sh[i] = 8'h00;
    void'($urandom(32'h19162b75));
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 13; i++) begin
      axr(at[i]);
      check("reset value", d, 32'h0);
    end
    chk_pins;
    $display("test reset values done");
    for (int k = 0; k < 20; k++) begin
      ext_s <= 5'($urandom); ext_i <= 1'($urandom); ext_p <= 7'($urandom);
      for (int i = 0; i < 9; i++) wreg(i, (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($urandom));
      chk_pins;
      for (int i = 0; i < 9; i++) begin
        axr(at[i]);
        check("readback", d, {24'h0, sh[i]});
      end
      axr(at[10]);
      check("sense input", d, {24'h0, exp_s()});
      axr(at[11]);
      check("indicator input", d, {31'h0, sh[1][0] ? sh[3][0] : ext_i});
      axr(at[12]);
      check("power input", d, {24'h0, exp_p()});
    end
    $display("test random access done");
    for (int i = 10; i < 13; i++) begin
      axw(at[i], 8'hff, 4'h1);
      check("input write response", 32'(r), 32'(RESP_OKAY));
    end
    axr(at[12]);
    check("power input after write", d, {24'h0, exp_p()});
    axw(at[0], ~sh[0], 4'he);
    axr(at[0]);
    check("strobe off write", d, {24'h0, sh[0]});
    axw(16'h2104, 8'h5a, 4'h1);
    check("unmapped write", 32'(r), 32'(RESP_SLVERR));
    axr(16'h2104);
    check("unmapped read", d, 32'h0);
    check("unmapped read response", 32'(r), 32'(RESP_SLVERR));
    $display("test refused access done");
    ext_en <= 1'b0;
    wreg(0, 8'h00); wreg(1, 8'h00); wreg(7, 8'h00); wreg(4, 8'h1f); wreg(5, 8'h01); wreg(6, 8'hfe);
    repeat (4) @(posedge sys_clk);
    axr(at[10]);
    check("pulled up sense", d, 32'h1f);
    axr(at[11]);
    check("pulled up indicator", d, 32'h1);
    axr(at[12]);
    check("pulled down power", d, 32'h0);
    ext_en <= 1'b1;
    ext_s <= 5'h00;
    repeat (4) @(posedge sys_clk);
    ext_s <= 5'h15;
    axr(at[10]);
    check("sense before sync", d, 32'h0);
    axr(at[10]);
    check("sense after sync", d, 32'h15);
    $display("test pulls and sync done");
    wreg(1, 8'h01); wreg(3, 8'h01); wreg(9, 8'h01);
    for (int k = 0; k < 4; k++) begin
      led <= k[0];
      if (k == 2) wreg(3, 8'h00);
      repeat (3) @(posedge sys_clk);
      check("indicator mode out", 32'(i_out), 32'(k[0]));
    end
    wreg(9, 8'h00);
    repeat (3) @(posedge sys_clk);
    check("programmable mode out", 32'(i_out), 32'(sh[3][0]));
    $display("test indicator mode done");
    test_done;
  end
  initial begin
    #(4 * 40000);
    num_errors++;
    $display("ERROR watchdog expected finish seen timeout");
    test_done;
  end
endmodule
`default_nettype wire
